// file: pkg/pdtsc_map.svh
/*
 * Register offsets, writable-bit masks, field layouts, reset values and threshold voltages
 * of the threshold and edge-rate configuration bank.
 * Assumes it is included by its bare name wherever the constants are needed.
 */
`ifndef PDTSC_MAP_SVH
`define PDTSC_MAP_SVH

`define PDTSC_ADDR_W 10
`define PDTSC_NUM_REGS 9
`define PDTSC_NUM_HS 7
`define PDTSC_NUM_LS 8
`define PDTSC_NUM_OUT 15
`define PDTSC_NUM_CORES 6

`define PDTSC_OFS_HS_DRAIN_A 10'h16B
`define PDTSC_OFS_HS_DRAIN_B 10'h16C
`define PDTSC_OFS_HS_SOURCE_A 10'h16D
`define PDTSC_OFS_HS_SOURCE_B 10'h16E
`define PDTSC_OFS_LS_DRAIN_A 10'h16F
`define PDTSC_OFS_LS_DRAIN_B 10'h170
`define PDTSC_OFS_HS_RATE 10'h171
`define PDTSC_OFS_LS_RATE_A 10'h172
`define PDTSC_OFS_LS_RATE_B 10'h173

`define PDTSC_IDX_HS_DRAIN_A 4'h0
`define PDTSC_IDX_HS_DRAIN_B 4'h1
`define PDTSC_IDX_HS_SOURCE_A 4'h2
`define PDTSC_IDX_HS_SOURCE_B 4'h3
`define PDTSC_IDX_LS_DRAIN_A 4'h4
`define PDTSC_IDX_LS_DRAIN_B 4'h5
`define PDTSC_IDX_HS_RATE 4'h6
`define PDTSC_IDX_LS_RATE_A 4'h7
`define PDTSC_IDX_LS_RATE_B 4'h8

`define PDTSC_MASK_HS_DRAIN_A 16'hFFFF
`define PDTSC_MASK_HS_DRAIN_B 16'h0FFF
`define PDTSC_MASK_HS_SOURCE_A 16'hFFFF
`define PDTSC_MASK_HS_SOURCE_B 16'h0FFF
`define PDTSC_MASK_LS_DRAIN_A 16'hFFFF
`define PDTSC_MASK_LS_DRAIN_B 16'hFFFF
`define PDTSC_MASK_HS_RATE 16'h3FFF
`define PDTSC_MASK_LS_RATE_A 16'h0FFF
`define PDTSC_MASK_LS_RATE_B 16'h00FF

`define PDTSC_REG_RESET 16'h0000

`define PDTSC_THR_W 4
`define PDTSC_RATE_W 2
`define PDTSC_THR_PER_REG 4
`define PDTSC_RATE_PER_REG 8
`define PDTSC_MV_W 12

`define PDTSC_CODE_0V00 4'h0
`define PDTSC_CODE_0V10 4'h9
`define PDTSC_CODE_0V20 4'hA
`define PDTSC_CODE_0V30 4'hB
`define PDTSC_CODE_0V40 4'hC
`define PDTSC_CODE_0V50 4'h1
`define PDTSC_CODE_1V00 4'h2
`define PDTSC_CODE_1V50 4'h3
`define PDTSC_CODE_2V00 4'h4
`define PDTSC_CODE_2V50 4'h5
`define PDTSC_CODE_3V00 4'h6
`define PDTSC_CODE_3V50 4'h7

`define PDTSC_MV_0V00 12'h000
`define PDTSC_MV_0V10 12'h064
`define PDTSC_MV_0V20 12'h0C8
`define PDTSC_MV_0V30 12'h12C
`define PDTSC_MV_0V40 12'h190
`define PDTSC_MV_0V50 12'h1F4
`define PDTSC_MV_1V00 12'h3E8
`define PDTSC_MV_1V50 12'h5DC
`define PDTSC_MV_2V00 12'h7D0
`define PDTSC_MV_2V50 12'h9C4
`define PDTSC_MV_3V00 12'hBB8
`define PDTSC_MV_3V50 12'hDAC

`endif

// file: pkg/pdtsc_pkg.sv
/*
 * Types shared by the threshold and edge-rate configuration bank.
 * Assumes pdtsc_map.svh is on the include path.
 */
`include "pdtsc_map.svh"

package pdtsc_pkg;

    typedef logic [`PDTSC_ADDR_W-1:0] pdtsc_addr_t;
    typedef logic [15:0] pdtsc_word_t;

    // Register access as presented by the serial interface shell.
    typedef struct packed {
        logic wr;
        logic rd;
        pdtsc_addr_t addr;
        pdtsc_word_t wdata;
    } pdtsc_host_req_s;

    // One field update requested by a microcore.
    typedef struct packed {
        logic valid;
        logic [2:0] core;
        pdtsc_addr_t addr;
        logic [2:0] field;
        logic [`PDTSC_THR_W-1:0] value;
    } pdtsc_core_req_s;

    // Access rights: one core mask per output, high side 0..6, low side 7..14.
    typedef logic [`PDTSC_NUM_OUT-1:0][`PDTSC_NUM_CORES-1:0] pdtsc_rights_t;

    typedef struct packed {
        logic [`PDTSC_RATE_W-1:0] rise;
        logic [`PDTSC_RATE_W-1:0] fall;
    } pdtsc_rate_s;

endpackage

// file: verilog/pdtsc_thr_decode.sv
/*
 * Decodes one four-bit monitoring threshold code into millivolts, registered.
 * Assumes the code comes from logic on the same clock.
 */
`timescale 1ns/1ps
`include "pdtsc_map.svh"

module pdtsc_thr_decode (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`PDTSC_THR_W-1:0] code,
    output logic [`PDTSC_MV_W-1:0] millivolts,
    output logic code_valid
);

    logic [`PDTSC_MV_W-1:0] next_millivolts;
    logic next_code_valid;

    // Same table for high-side drain/source and low-side drain comparators.
    always_comb begin
        next_code_valid = 1'b1;
        case (code)
            `PDTSC_CODE_0V00: next_millivolts = `PDTSC_MV_0V00;
            `PDTSC_CODE_0V10: next_millivolts = `PDTSC_MV_0V10;
            `PDTSC_CODE_0V20: next_millivolts = `PDTSC_MV_0V20;
            `PDTSC_CODE_0V30: next_millivolts = `PDTSC_MV_0V30;
            `PDTSC_CODE_0V40: next_millivolts = `PDTSC_MV_0V40;
            `PDTSC_CODE_0V50: next_millivolts = `PDTSC_MV_0V50;
            `PDTSC_CODE_1V00: next_millivolts = `PDTSC_MV_1V00;
            `PDTSC_CODE_1V50: next_millivolts = `PDTSC_MV_1V50;
            `PDTSC_CODE_2V00: next_millivolts = `PDTSC_MV_2V00;
            `PDTSC_CODE_2V50: next_millivolts = `PDTSC_MV_2V50;
            `PDTSC_CODE_3V00: next_millivolts = `PDTSC_MV_3V00;
            `PDTSC_CODE_3V50: next_millivolts = `PDTSC_MV_3V50;
            default: begin
                // Undefined codes fall back to the lowest threshold and are flagged.
                next_millivolts = `PDTSC_MV_0V00;
                next_code_valid = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            millivolts <= `PDTSC_MV_0V00;
            code_valid <= 1'b1;
        end else begin
            millivolts <= next_millivolts;
            code_valid <= next_code_valid;
        end
    end

endmodule

// file: verilog/pdtsc_bank.sv
/*
 * Threshold and edge-rate configuration bank of the gate pre-driver: nine 16-bit registers written
 * by the host over the serial register port and updated field by field by microcores.
 * Assumes the serial shell and the microcores run on clock, and that the access-right table and
 * the bootstrap logic that supplies the thresholds in effect sit outside this block.
 */
`timescale 1ns/1ps
`include "pdtsc_map.svh"

// Function
// - four-bit threshold field per pre-driver output
// - host writes threshold registers over serial port
// - microcore update only with output access right
// - high-side reads return thresholds in effect
// - high-side code to voltage mapping
// - low-side drain uses same code mapping
// - edge-rate field stored for every driver
// - one rate both edges, except low-side seven/eight
module pdtsc_bank (
    input wire logic clock,
    input wire logic nrst,
    input wire pdtsc_pkg::pdtsc_host_req_s host_req,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    output logic host_hit,
    input wire pdtsc_pkg::pdtsc_core_req_s core_req,
    output logic core_done,
    output logic core_refused,
    input wire pdtsc_pkg::pdtsc_rights_t rights,
    input wire logic [`PDTSC_NUM_HS*`PDTSC_THR_W-1:0] hs_drain_thr_in_effect,
    input wire logic [`PDTSC_NUM_HS*`PDTSC_THR_W-1:0] hs_source_thr_in_effect,
    output logic [`PDTSC_NUM_HS-1:0][`PDTSC_THR_W-1:0] hs_drain_thr,
    output logic [`PDTSC_NUM_HS-1:0][`PDTSC_THR_W-1:0] hs_source_thr,
    output logic [`PDTSC_NUM_LS-1:0][`PDTSC_THR_W-1:0] ls_drain_thr,
    output logic [`PDTSC_NUM_HS-1:0][`PDTSC_MV_W-1:0] hs_drain_mv,
    output logic [`PDTSC_NUM_HS-1:0][`PDTSC_MV_W-1:0] hs_source_mv,
    output logic [`PDTSC_NUM_LS-1:0][`PDTSC_MV_W-1:0] ls_drain_mv,
    output logic [`PDTSC_NUM_HS+`PDTSC_NUM_HS+`PDTSC_NUM_LS-1:0] thr_code_valid,
    output pdtsc_pkg::pdtsc_rate_s [`PDTSC_NUM_OUT-1:0] edge_rate
);

    logic [15:0] regs [`PDTSC_NUM_REGS];
    logic [15:0] next_regs [`PDTSC_NUM_REGS];
    logic [15:0] next_host_rdata;
    logic next_host_rvalid;
    logic next_core_done;
    logic next_core_refused;

    logic [4:0] host_dec;
    logic [4:0] core_dec;
    logic [3:0] host_idx;
    logic host_map;
    logic [3:0] core_idx;
    logic core_map;
    logic [15:0] core_fmask;
    logic [15:0] core_fdata;
    logic [4:0] core_out;
    logic core_field_ok;
    logic core_granted;

    // Offset to storage index; shared by the host and the microcore paths.
    function automatic logic [4:0] pdtsc_decode(input pdtsc_pkg::pdtsc_addr_t addr);
        logic [4:0] r;
        r = 5'h10;
        case (addr)
            `PDTSC_OFS_HS_DRAIN_A: r = {1'b0, `PDTSC_IDX_HS_DRAIN_A};
            `PDTSC_OFS_HS_DRAIN_B: r = {1'b0, `PDTSC_IDX_HS_DRAIN_B};
            `PDTSC_OFS_HS_SOURCE_A: r = {1'b0, `PDTSC_IDX_HS_SOURCE_A};
            `PDTSC_OFS_HS_SOURCE_B: r = {1'b0, `PDTSC_IDX_HS_SOURCE_B};
            `PDTSC_OFS_LS_DRAIN_A: r = {1'b0, `PDTSC_IDX_LS_DRAIN_A};
            `PDTSC_OFS_LS_DRAIN_B: r = {1'b0, `PDTSC_IDX_LS_DRAIN_B};
            `PDTSC_OFS_HS_RATE: r = {1'b0, `PDTSC_IDX_HS_RATE};
            `PDTSC_OFS_LS_RATE_A: r = {1'b0, `PDTSC_IDX_LS_RATE_A};
            `PDTSC_OFS_LS_RATE_B: r = {1'b0, `PDTSC_IDX_LS_RATE_B};
            default: r = 5'h10;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] pdtsc_mask(input logic [3:0] idx);
        logic [15:0] m;
        m = 16'h0000;
        case (idx)
            `PDTSC_IDX_HS_DRAIN_A: m = `PDTSC_MASK_HS_DRAIN_A;
            `PDTSC_IDX_HS_DRAIN_B: m = `PDTSC_MASK_HS_DRAIN_B;
            `PDTSC_IDX_HS_SOURCE_A: m = `PDTSC_MASK_HS_SOURCE_A;
            `PDTSC_IDX_HS_SOURCE_B: m = `PDTSC_MASK_HS_SOURCE_B;
            `PDTSC_IDX_LS_DRAIN_A: m = `PDTSC_MASK_LS_DRAIN_A;
            `PDTSC_IDX_LS_DRAIN_B: m = `PDTSC_MASK_LS_DRAIN_B;
            `PDTSC_IDX_HS_RATE: m = `PDTSC_MASK_HS_RATE;
            `PDTSC_IDX_LS_RATE_A: m = `PDTSC_MASK_LS_RATE_A;
            `PDTSC_IDX_LS_RATE_B: m = `PDTSC_MASK_LS_RATE_B;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    assign host_dec = pdtsc_decode(host_req.addr);
    assign host_idx = host_dec[3:0];
    assign host_map = ~host_dec[4];
    assign core_dec = pdtsc_decode(core_req.addr);
    assign core_idx = core_dec[3:0];
    assign core_map = ~core_dec[4];

    // Locate the addressed field, its bit lane and the output it controls.
    always_comb begin
        core_fmask = 16'h0000;
        core_fdata = 16'h0000;
        core_out = 5'h00;
        case (core_idx)
            `PDTSC_IDX_HS_DRAIN_A, `PDTSC_IDX_HS_SOURCE_A, `PDTSC_IDX_LS_DRAIN_A,
            `PDTSC_IDX_HS_DRAIN_B, `PDTSC_IDX_HS_SOURCE_B, `PDTSC_IDX_LS_DRAIN_B: begin
                // Only four fields exist here; fields 4..7 would alias the low ones, so they are refused.
                core_fmask = core_req.field[2] ? 16'h0000 : (16'h000F << {core_req.field[1:0], 2'h0});
                core_fdata = {12'h000, core_req.value} << {core_req.field[1:0], 2'h0};
                core_out = {3'h0, core_req.field[1:0]};
                if (core_idx == `PDTSC_IDX_HS_DRAIN_B || core_idx == `PDTSC_IDX_HS_SOURCE_B) begin
                    core_out = 5'(core_out + 5'h04);
                end else if (core_idx == `PDTSC_IDX_LS_DRAIN_A) begin
                    core_out = 5'(core_out + 5'h07);
                end else if (core_idx == `PDTSC_IDX_LS_DRAIN_B) begin
                    core_out = 5'(core_out + 5'h0B);
                end
            end
            `PDTSC_IDX_HS_RATE, `PDTSC_IDX_LS_RATE_A: begin
                core_fmask = 16'h0003 << {core_req.field, 1'b0};
                core_fdata = {14'h0000, core_req.value[1:0]} << {core_req.field, 1'b0};
                core_out = (core_idx == `PDTSC_IDX_HS_RATE) ? {2'h0, core_req.field} : 5'(core_req.field + 5'h07);
            end
            `PDTSC_IDX_LS_RATE_B: begin
                // Fields 0..1 belong to low side 7, fields 2..3 to low side 8.
                core_fmask = 16'h0003 << {core_req.field, 1'b0};
                core_fdata = {14'h0000, core_req.value[1:0]} << {core_req.field, 1'b0};
                core_out = core_req.field[1] ? 5'h0E : 5'h0D;
            end
            default: begin
                core_fmask = 16'h0000;
            end
        endcase
    end

    // A field that lands only on reserved bits is refused like a missing right.
    assign core_field_ok = core_map && ((core_fmask & pdtsc_mask(core_idx)) == core_fmask) && (core_fmask != 16'h0000);
    // The requesting core must hold the right to the output the field belongs to.
    assign core_granted = core_req.valid && core_field_ok && (core_req.core < 3'(`PDTSC_NUM_CORES))
        && rights[core_out[3:0]][core_req.core];

    always_comb begin
        for (int i = 0; i < `PDTSC_NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        // Host writes store only the defined bits.
        if (host_req.wr && host_map) begin
            next_regs[host_idx] = host_req.wdata & pdtsc_mask(host_idx);
        end
        // Applied after the host write, so the core's field wins a same-cycle clash.
        if (core_granted) begin
            next_regs[core_idx] = (next_regs[core_idx] & ~core_fmask) | core_fdata;
        end
        next_core_done = core_granted;
        next_core_refused = core_req.valid && !core_granted;
    end

    // Read path: high-side thresholds report the configuration in effect, not the stored word.
    always_comb begin
        next_host_rvalid = host_req.rd;
        next_host_rdata = 16'h0000;
        if (host_req.rd && host_map) begin
            case (host_idx)
                `PDTSC_IDX_HS_DRAIN_A: next_host_rdata = hs_drain_thr_in_effect[15:0];
                `PDTSC_IDX_HS_DRAIN_B: next_host_rdata = {4'h0, hs_drain_thr_in_effect[27:16]};
                `PDTSC_IDX_HS_SOURCE_A: next_host_rdata = hs_source_thr_in_effect[15:0];
                `PDTSC_IDX_HS_SOURCE_B: next_host_rdata = {4'h0, hs_source_thr_in_effect[27:16]};
                default: next_host_rdata = regs[host_idx] & pdtsc_mask(host_idx);
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `PDTSC_NUM_REGS; i++) begin
                regs[i] <= `PDTSC_REG_RESET;
            end
            host_rdata <= 16'h0000;
            host_rvalid <= 1'b0;
            core_done <= 1'b0;
            core_refused <= 1'b0;
        end else begin
            for (int i = 0; i < `PDTSC_NUM_REGS; i++) begin
                regs[i] <= next_regs[i];
            end
            host_rdata <= next_host_rdata;
            host_rvalid <= next_host_rvalid;
            core_done <= next_core_done;
            core_refused <= next_core_refused;
        end
    end

    assign host_hit = host_map;

    // One four-bit field per drain or source comparator, each decoded to its comparator level.
    genvar g;
    generate
        for (g = 0; g < `PDTSC_NUM_LS; g++) begin : g_out
            if (g < `PDTSC_NUM_HS) begin : g_hs
                assign hs_drain_thr[g] = regs[g / 4][(g % 4) * 4 +: 4];
                assign hs_source_thr[g] = regs[2 + g / 4][(g % 4) * 4 +: 4];
                pdtsc_thr_decode u_hs_drain (
                    .clock(clock),
                    .nrst(nrst),
                    .code(hs_drain_thr[g]),
                    .millivolts(hs_drain_mv[g]),
                    .code_valid(thr_code_valid[g])
                );
                pdtsc_thr_decode u_hs_source (
                    .clock(clock),
                    .nrst(nrst),
                    .code(hs_source_thr[g]),
                    .millivolts(hs_source_mv[g]),
                    .code_valid(thr_code_valid[`PDTSC_NUM_HS + g])
                );
                // One high-side selection drives both edges.
                assign edge_rate[g].rise = regs[`PDTSC_IDX_HS_RATE][g * 2 +: 2];
                assign edge_rate[g].fall = regs[`PDTSC_IDX_HS_RATE][g * 2 +: 2];
            end
            assign ls_drain_thr[g] = regs[4 + g / 4][(g % 4) * 4 +: 4];
            pdtsc_thr_decode u_ls_drain (
                .clock(clock),
                .nrst(nrst),
                .code(ls_drain_thr[g]),
                .millivolts(ls_drain_mv[g]),
                .code_valid(thr_code_valid[2 * `PDTSC_NUM_HS + g])
            );
            if (g < 6) begin : g_ls_slow
                // Low sides 1..6 share one selection for both edges.
                assign edge_rate[`PDTSC_NUM_HS + g].rise = regs[`PDTSC_IDX_LS_RATE_A][g * 2 +: 2];
                assign edge_rate[`PDTSC_NUM_HS + g].fall = regs[`PDTSC_IDX_LS_RATE_A][g * 2 +: 2];
            end else begin : g_ls_fast
                // Low sides 7 and 8 keep separate rising and falling selections.
                assign edge_rate[`PDTSC_NUM_HS + g].rise = regs[`PDTSC_IDX_LS_RATE_B][(g - 6) * 4 +: 2];
                assign edge_rate[`PDTSC_NUM_HS + g].fall = regs[`PDTSC_IDX_LS_RATE_B][(g - 6) * 4 + 2 +: 2];
            end
        end
    endgenerate

endmodule

// file: verification/pdtsc_bank_monitor.sv
/* Port checker of the threshold and edge-rate bank.
   Assumes one clock and the active-low asynchronous reset of the bank. */
`timescale 1ns/1ps
`include "pdtsc_map.svh"
module pdtsc_bank_monitor (
    input wire logic clock,
    input wire logic nrst,
    input wire pdtsc_pkg::pdtsc_host_req_s host_req,
    input wire logic [15:0] host_rdata,
    input wire logic host_rvalid,
    input wire logic host_hit,
    input wire pdtsc_pkg::pdtsc_core_req_s core_req,
    input wire logic core_done,
    input wire logic core_refused,
    input wire logic [`PDTSC_NUM_HS*`PDTSC_THR_W-1:0] hs_drain_thr_in_effect,
    input wire logic [`PDTSC_NUM_LS-1:0][`PDTSC_THR_W-1:0] ls_drain_thr,
    input wire logic [`PDTSC_NUM_LS-1:0][`PDTSC_MV_W-1:0] ls_drain_mv,
    input wire pdtsc_pkg::pdtsc_rate_s [`PDTSC_NUM_OUT-1:0] edge_rate
);
    logic same_rate;
    // Only the two fast low-side drivers may run different rates on their edges.
    always_comb begin
        same_rate = 1'b1;
        for (int i = 0; i < 13; i++) begin
            same_rate &= edge_rate[i].rise == edge_rate[i].fall;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_READ_ANSWER: assert property (host_req.rd |=> host_rvalid)
        else $error("read got no answer");
    AST_READ_QUIET: assert property (!host_req.rd |=> !host_rvalid && host_rdata == 16'h0000)
        else $error("read answer without read");
    AST_UNMAPPED_ZERO: assert property (host_req.rd && !host_hit |=> host_rdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_HIT_RANGE: assert property (host_hit == (host_req.addr >= `PDTSC_OFS_HS_DRAIN_A
        && host_req.addr <= `PDTSC_OFS_LS_RATE_B)) else $error("offset hit wrong");
    AST_HS_IN_EFFECT: assert property (host_req.rd && host_req.addr == `PDTSC_OFS_HS_DRAIN_A
        |=> host_rdata == $past(hs_drain_thr_in_effect[15:0])) else $error("high-side read not in effect");
    AST_LS_WRITE: assert property (host_req.wr && !core_req.valid && host_req.addr == `PDTSC_OFS_LS_DRAIN_A
        |=> ls_drain_thr[3:0] == $past(host_req.wdata)) else $error("low-side write lost");
    AST_CORE_ONE_ANSWER: assert property (core_req.valid |=> core_done != core_refused)
        else $error("core update not answered once");
    AST_CORE_BAD_ID: assert property (core_req.valid && core_req.core > 3'h5 |=> core_refused)
        else $error("unknown core granted");
    AST_CORE_QUIET: assert property (!core_req.valid |=> !core_done && !core_refused)
        else $error("core answer without request");
    AST_RATE_BOTH_EDGES: assert property (same_rate)
        else $error("edge rates differ");
    AST_LS_DECODE: assert property (ls_drain_thr[0] == `PDTSC_CODE_3V50 |=> ls_drain_mv[0] == `PDTSC_MV_3V50)
        else $error("low-side decode wrong");
endmodule
bind pdtsc_bank pdtsc_bank_monitor u_mon (.clock(clock), .nrst(nrst), .host_req(host_req),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_hit(host_hit), .core_req(core_req),
    .core_done(core_done), .core_refused(core_refused), .hs_drain_thr_in_effect(hs_drain_thr_in_effect),
    .ls_drain_thr(ls_drain_thr), .ls_drain_mv(ls_drain_mv), .edge_rate(edge_rate));

// file: verification/pdtsc_host_model.sv
/* Host and microcore request model facing the bank.
   Assumes the bench calls one task at a time on the bank's clock. */
`timescale 1ns/1ps
module pdtsc_host_model (
    input wire logic clock,
    output pdtsc_pkg::pdtsc_host_req_s host_req,
    output pdtsc_pkg::pdtsc_core_req_s core_req,
    input wire logic [15:0] host_rdata,
    input wire logic core_done,
    input wire logic core_refused
);
    initial begin
        host_req = '0;
        core_req = '0;
    end
    // Qualifiers are cleared and the payload inverted after each strobe so that no stale value can pass for a good one.
    task automatic host_access(input logic wr, input logic rd, input pdtsc_pkg::pdtsc_addr_t addr,
                               input logic [15:0] wdata, output logic [15:0] rdata);
        @(posedge clock);
        host_req <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
        @(posedge clock);
        host_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        #1 rdata = host_rdata;
    endtask
    task automatic core_update(input logic [2:0] core, input pdtsc_pkg::pdtsc_addr_t addr,
                               input logic [2:0] field, input logic [3:0] value, output logic [1:0] answer);
        @(posedge clock);
        core_req <= '{valid: 1'b1, core: core, addr: addr, field: field, value: value};
        @(posedge clock);
        core_req <= '{valid: 1'b0, core: ~core, addr: ~addr, field: ~field, value: ~value};
        #1 answer = {core_done, core_refused};
    endtask
endmodule

// file: verification/tb_pdtsc_bank.sv
/* Self-checking bench of the bank: register rows, decode, core updates, reset in mid-run.
   Assumes the host model drives requests and the bench drives rights and in-effect codes. */
`timescale 1ns/1ps
`include "pdtsc_map.svh"
module tb_pdtsc_bank;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    pdtsc_pkg::pdtsc_host_req_s host_req;
    pdtsc_pkg::pdtsc_core_req_s core_req;
    pdtsc_pkg::pdtsc_rights_t rights = '0;
    logic [27:0] drain_eff = '0;
    logic [27:0] source_eff = '0;
    logic [15:0] host_rdata;
    logic host_rvalid;
    logic host_hit;
    logic core_done;
    logic core_refused;
    logic [6:0][3:0] hs_drain_thr;
    logic [6:0][3:0] hs_source_thr;
    logic [7:0][3:0] ls_drain_thr;
    logic [6:0][11:0] hs_drain_mv;
    logic [6:0][11:0] hs_source_mv;
    logic [7:0][11:0] ls_drain_mv;
    logic [21:0] thr_code_valid;
    pdtsc_pkg::pdtsc_rate_s [14:0] edge_rate;
    int n_errors = 0;
    int n_checks = 0;
    logic [15:0] rd_word;
    logic [1:0] answer;
    logic [41:0] rows [10] = '{{10'h16B, 16'hFFFF, 16'h4567}, {10'h16C, 16'hFFFF, 16'h0123},
        {10'h16D, 16'hFFFF, 16'h4321}, {10'h16E, 16'hFFFF, 16'h0765}, {10'h16F, 16'hFFFF, 16'hFFFF},
        {10'h170, 16'hFFFF, 16'hFFFF}, {10'h171, 16'hFFFF, 16'h3FFF}, {10'h172, 16'hFFFF, 16'h0FFF},
        {10'h173, 16'hFFFF, 16'h00FF}, {10'h3FF, 16'hFFFF, 16'h0000}};
    pdtsc_bank dut (.clock(clock), .nrst(nrst), .host_req(host_req), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .host_hit(host_hit), .core_req(core_req), .core_done(core_done),
        .core_refused(core_refused), .rights(rights), .hs_drain_thr_in_effect(drain_eff),
        .hs_source_thr_in_effect(source_eff), .hs_drain_thr(hs_drain_thr), .hs_source_thr(hs_source_thr),
        .ls_drain_thr(ls_drain_thr), .hs_drain_mv(hs_drain_mv), .hs_source_mv(hs_source_mv),
        .ls_drain_mv(ls_drain_mv), .thr_code_valid(thr_code_valid), .edge_rate(edge_rate));
    pdtsc_host_model u_host (.clock(clock), .host_req(host_req), .core_req(core_req),
        .host_rdata(host_rdata), .core_done(core_done), .core_refused(core_refused));
    initial forever #5 clock = ~clock;
    task automatic check(input logic [63:0] seen, input logic [63:0] expected);
        n_checks++;
        if (seen !== expected) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [12:0] decode(input logic [3:0] code);
        case (code)
            4'h0: return {1'b1, 12'h000};
            4'h9: return {1'b1, 12'h064};
            4'hA: return {1'b1, 12'h0C8};
            4'hB: return {1'b1, 12'h12C};
            4'hC: return {1'b1, 12'h190};
            4'h1: return {1'b1, 12'h1F4};
            4'h2: return {1'b1, 12'h3E8};
            4'h3: return {1'b1, 12'h5DC};
            4'h4: return {1'b1, 12'h7D0};
            4'h5: return {1'b1, 12'h9C4};
            4'h6: return {1'b1, 12'hBB8};
            4'h7: return {1'b1, 12'hDAC};
            default: return 13'h0000;
        endcase
    endfunction
    task automatic reset_reads();
        for (int i = 0; i < 10; i++) begin
            u_host.host_access(1'b0, 1'b1, rows[i][41:32], 16'h0000, rd_word);
            check(rd_word, 16'h0000);
        end
        check(edge_rate, 64'h0);
        check(thr_code_valid, 22'h3FFFFF);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        reset_reads();
        @(posedge clock) drain_eff <= 28'h1234567;
        source_eff <= 28'h7654321;
        for (int i = 0; i < 10; i++) begin
            u_host.host_access(1'b1, 1'b0, rows[i][41:32], rows[i][31:16], rd_word);
            u_host.host_access(1'b0, 1'b1, rows[i][41:32], 16'h0000, rd_word);
            check(rd_word, rows[i][15:0]);
            check(host_rvalid, 1'b1);
        end
        check(hs_drain_thr, {7{4'hF}});
        check(hs_source_thr, {7{4'hF}});
        check(edge_rate, {15{4'hF}});
        for (int c = 0; c < 16; c++) begin
            u_host.host_access(1'b1, 1'b0, 10'h16F, {4{4'(c)}}, rd_word);
            u_host.host_access(1'b1, 1'b0, 10'h16B, {4{4'(c)}}, rd_word);
            u_host.host_access(1'b1, 1'b0, 10'h16D, {4{4'(c)}}, rd_word);
            @(posedge clock) #1 check({thr_code_valid[14], ls_drain_mv[0]}, decode(4'(c)));
            check({thr_code_valid[0], hs_drain_mv[0]}, decode(4'(c)));
            check({thr_code_valid[7], hs_source_mv[0]}, decode(4'(c)));
        end
        u_host.core_update(3'h2, 10'h16F, 3'h1, 4'h3, answer);
        check({answer, ls_drain_thr[1]}, 6'h1F);
        @(posedge clock) rights[8][2] <= 1'b1;
        u_host.core_update(3'h2, 10'h16F, 3'h1, 4'h3, answer);
        check({answer, ls_drain_thr[1]}, 6'h23);
        @(posedge clock) #1 check(ls_drain_mv[1], 12'h5DC);
        @(posedge clock) rights <= '1;
        u_host.core_update(3'h6, 10'h16F, 3'h0, 4'h1, answer);
        check(answer, 2'b01);
        u_host.core_update(3'h0, 10'h16C, 3'h3, 4'h1, answer);
        check(answer, 2'b01);
        u_host.core_update(3'h2, 10'h16F, 3'h5, 4'h5, answer);
        check({answer, ls_drain_thr[1]}, 6'h13);
        u_host.core_update(3'h0, 10'h174, 3'h0, 4'h1, answer);
        check(answer, 2'b01);
        u_host.core_update(3'h0, 10'h173, 3'h1, 4'h1, answer);
        check({answer, edge_rate[13]}, 6'h2D);
        u_host.core_update(3'h1, 10'h171, 3'h0, 4'h0, answer);
        check({answer, edge_rate[0]}, 6'h20);
        @(posedge clock) drain_eff <= '0;
        source_eff <= '0;
        nrst <= 1'b0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        reset_reads();
        complete_run();
    end
    initial begin
        #100us;
        n_errors++;
        complete_run();
    end
endmodule
